// *** design/fsr_device_end.sv ***
`default_nettype none
module fsr_device_end
    import fsr_pkg::*;
(
    fsr_link_if.device              link,
    input  wire logic               clk,
    input  wire logic               rst_n,
    output logic                    word_valid,
    output logic [WORD_W-1:0]       word,
    output logic [3:0]              word_ctrl,
    output logic [3:0]              word_addr,
    output logic [7:0]              word_data,
    output logic                    short_frame,
    output logic                    long_frame
);

    timeunit 1ns;
    timeprecision 1ns;

    // Shift register and bit count of the frame in progress; the newest bit
    // is not stored here but taken straight from the data line.
    typedef struct packed {
        logic [WORD_W-2:0] shift;
        logic [CNT_W-1:0]  count;
    } fsr_frame_s;

    // Each result leaves the serial clock domain as a toggle, so one flop
    // change per event is all that the synchroniser has to carry.
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic              done_tgl;
        logic              short_tgl;
        logic              long_tgl;
        logic              partial;
    } fsr_hold_s;

    // Three stages per toggle: two to settle it and a third to find its edge.
    typedef struct packed {
        logic [2:0]        s1;
        logic [2:0]        s2;
        logic [2:0]        s3;
        logic [WORD_W-1:0] word;
        logic              valid;
        logic              short_ev;
        logic              long_ev;
    } fsr_user_s;

    fsr_frame_s fr;
    fsr_frame_s next_fr;
    fsr_hold_s  hd;
    fsr_hold_s  next_hd;
    fsr_user_s  us;
    fsr_user_s  next_us;
    logic       frame_rst_n;
    logic [2:0] edge_seen;
    logic [1:0] rst_sync;
    logic       user_rst_n;

    // frame end clears
    // The frame state is cleared by the frame signal itself, because the
    // serial clock may stop right after the last bit and never tick again.
    assign frame_rst_n = rst_n & ~link.frame_sync_n;

    always_comb
    begin
        next_fr = fr;
        if (fr.count < CNT_FULL)
        begin
            next_fr.shift = {fr.shift[WORD_W-3:0], link.serial_data_in};
            next_fr.count = fr.count + 5'h01;
        end
        else
        begin
            // The count parks above full, so a long frame is reported once.
            next_fr.count = CNT_OVER;
        end
    end

    always_comb
    begin
        next_hd = hd;
        if (fr.count == CNT_LAST)
        begin
            next_hd.word     = {fr.shift, link.serial_data_in};
            next_hd.done_tgl = ~hd.done_tgl;
            next_hd.partial  = 1'b0;
        end
        // A short frame is only known at the first edge of the next frame,
        // because nothing here is clocked once the frame signal rises.
        // report discarded word
        if (fr.count == 5'h00)
        begin
            next_hd.partial = 1'b1;
            if (hd.partial)
            begin
                next_hd.short_tgl = ~hd.short_tgl;
            end
        end
        if (fr.count == CNT_FULL)
        begin
            next_hd.long_tgl = ~hd.long_tgl;
        end
    end

    // only sclk edges
    // Nothing here counts on an edge outside a frame, so a parked or a free
    // running serial clock behave the same.
    always_ff @(negedge link.sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            fr <= '0;
        end
        else
        begin
            fr <= next_fr;
        end
    end

    always_ff @(negedge link.sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hd <= '0;
        end
        else if (!link.frame_sync_n)
        begin
            hd <= next_hd;
        end
    end

    // Only settled stages are compared; the first may still be resolving.
    assign edge_seen = us.s2 ^ us.s3;

    always_comb
    begin
        next_us          = us;
        next_us.s1       = {hd.long_tgl, hd.short_tgl, hd.done_tgl};
        next_us.s2       = us.s1;
        next_us.s3       = us.s2;
        next_us.valid    = edge_seen[0];
        next_us.short_ev = edge_seen[1];
        next_us.long_ev  = edge_seen[2];
        // The held word is stable for a whole frame after its toggle, far
        // longer than the three cycles the toggle needs to cross.
        if (edge_seen[0])
        begin
            next_us.word = hd.word;
        end
    end

    // The reset release reaches the user domain through two flops, so it never
    // lands inside the setup window of the crossing stages.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign user_rst_n = rst_sync[1];

    always_ff @(posedge clk or negedge user_rst_n)
    begin
        if (!user_rst_n)
        begin
            us <= '0;
        end
        else
        begin
            us <= next_us;
        end
    end

    // Every output is a user-domain flop, so no path from the serial clock
    // reaches a pin without passing the synchroniser.
    assign word_valid  = us.valid;
    assign word        = us.word;
    assign short_frame = us.short_ev;
    assign long_frame  = us.long_ev;

    assign word_ctrl = us.word[CTRL_MSB:CTRL_LSB];
    assign word_addr = us.word[ADDR_MSB:ADDR_LSB];
    assign word_data = us.word[DATA_MSB:DATA_LSB];

endmodule
`default_nettype wire

// *** design/fsr_host_end.sv ***
`default_nettype none
module fsr_host_end
    import fsr_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic [WORD_W-1:0]  req_word,
    input  wire logic               req_byte_mode,
    input  wire logic               req_lsb_first,
    fsr_link_if.host                link
);

    timeunit 1ns;
    timeprecision 1ns;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HIGH = 5'b00010,
        ST_LOW  = 5'b00100,
        ST_GAP  = 5'b01000,
        ST_TAIL = 5'b10000
    } fsr_state_e;

    typedef struct packed {
        fsr_state_e        state;
        logic [7:0]        tick;
        logic [CNT_W-1:0]  bits;
        logic [WORD_W-1:0] shift;
        logic              byte_mode;
        logic              sclk;
        logic              fsn;
        logic              sdi;
        logic              ready;
    } fsr_host_s;

    fsr_host_s q;
    fsr_host_s next_q;
    logic      frame_act;
    logic      half_done;
    logic [WORD_W-1:0] rev_word;

    assign half_done = (q.tick >= SCLK_HALF - CNT_ONE);
    assign rev_word  = {<<{req_word}};

    always_comb
    begin
        next_q      = q;
        frame_act   = ~q.fsn;
        next_q.tick = half_done ? 8'h00 : q.tick + CNT_ONE;
        unique case (q.state)
            ST_IDLE:
            begin
                next_q.tick = 8'h00;
                if (req_valid)
                begin
                    next_q.shift     = req_lsb_first ? rev_word : req_word;
                    next_q.sdi       = next_q.shift[WORD_W-1];
                    next_q.byte_mode = req_byte_mode;
                    next_q.bits      = '0;
                    next_q.ready     = 1'b0;
                    next_q.state     = ST_HIGH;
                    frame_act = 1'b1;
                end
            end
            ST_HIGH:
            begin
                if (half_done)
                begin
                    next_q.sclk  = 1'b0;
                    next_q.state = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (half_done)
                begin
                    next_q.sclk = 1'b1;
                    next_q.bits = q.bits + 5'h01;
                    next_q.shift = {q.shift[WORD_W-2:0], 1'b0};
                    next_q.sdi   = q.shift[WORD_W-2];
                    if (q.bits == CNT_LAST)
                    begin
                        next_q.state = ST_TAIL;
                    end
                    else if (q.byte_mode && q.bits == BYTE_LAST)
                    begin
                        next_q.state = ST_GAP;
                    end
                    else
                    begin
                        next_q.state = ST_HIGH;
                    end
                end
            end
            ST_GAP:
            begin
                next_q.tick = q.tick + CNT_ONE;
                if (q.tick >= BYTE_GAP - CNT_ONE)
                begin
                    next_q.tick  = 8'h00;
                    next_q.state = ST_HIGH;
                end
            end
            ST_TAIL:
            begin
                if (half_done)
                begin
                    frame_act    = 1'b0;
                    next_q.ready = 1'b1;
                    next_q.state = ST_IDLE;
                end
            end
        endcase
        next_q.fsn = ~frame_act;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q       <= '0;
            q.state <= ST_IDLE;
            q.sclk  <= 1'b1;
            q.fsn   <= 1'b1;
            q.ready <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign req_ready           = q.ready;
    assign link.sclk           = q.sclk;
    assign link.frame_sync_n   = q.fsn;
    assign link.serial_data_in = q.sdi;

endmodule
`default_nettype wire

// *** design/fsr_link_if.sv ***
`default_nettype none
interface fsr_link_if;
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk;
    logic frame_sync_n;
    logic serial_data_in;
    modport host
    (
        output sclk,
        output frame_sync_n,
        output serial_data_in
    );
    modport device
    (
        input sclk,
        input frame_sync_n,
        input serial_data_in
    );
endinterface
`default_nettype wire

// *** design/fsr_pkg.sv ***
`default_nettype none
package fsr_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned CNT_W      = 5;
    // Field layout of a word that targets a destination register.
    localparam int unsigned CTRL_MSB   = 15;
    localparam int unsigned CTRL_LSB   = 12;
    localparam int unsigned ADDR_MSB   = 11;
    localparam int unsigned ADDR_LSB   = 8;
    localparam int unsigned DATA_MSB   = 7;
    localparam int unsigned DATA_LSB   = 0;
    localparam logic [4:0]  CNT_LAST   = 5'h0f;
    localparam logic [4:0]  CNT_FULL   = 5'h10;
    localparam logic [4:0]  CNT_OVER   = 5'h11;
    localparam logic [4:0]  BYTE_LAST  = 5'h07;
    // Timing of the host end.
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned SCLK_MAX_HZ  = 40_000_000;
    localparam int unsigned HALF_RAW     = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam logic [7:0]  SCLK_HALF    = (HALF_RAW < 1) ? 8'h01 : 8'(HALF_RAW);
    localparam logic [7:0]  BYTE_GAP     = 8'h08;
    localparam logic [7:0]  CNT_ONE      = 8'h01;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage
`default_nettype wire

// *** verification/fsr_link_checker.sv ***
`default_nettype none
module fsr_link_checker
    import fsr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sclk,
    input  wire logic frame_sync_n,
    input  wire logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed
    {
        logic [4:0] cnt;
        logic       sclk_d;
    } fsr_chk_s;
    fsr_chk_s st;
    fsr_chk_s next_st;
    // Falling clock edges seen in the current frame.
    always_comb
    begin
        next_st = st;
        next_st.sclk_d = sclk;
        if (frame_sync_n)
            next_st.cnt = 5'h00;
        else if (st.sclk_d && !sclk)
            next_st.cnt = st.cnt + 5'h01;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '{cnt: 5'h00, sclk_d: 1'b1};
        else
            st <= next_st;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_idle_clock_high: assert property (frame_sync_n |-> sclk)
        else $error("serial clock low outside a frame");
    a_fall_in_frame: assert property ($fell(sclk) |-> !frame_sync_n)
        else $error("serial clock fell outside a frame");
    a_low_one_cycle: assert property ($fell(sclk) |=> sclk)
        else $error("serial clock low longer than one cycle");
    a_data_stable_fall: assert property ($fell(sclk) |-> $stable(serial_data_in))
        else $error("serial data moved at the sampling edge");
    a_frame_full_count: assert property ($rose(frame_sync_n) |-> st.cnt == 5'h10)
        else $error("frame closed without sixteen bits");
    a_count_bound: assert property (!frame_sync_n |-> st.cnt <= 5'h10)
        else $error("more than sixteen bits in a frame");
    a_frame_closes: assert property ((st.cnt == 5'h10 && !frame_sync_n)
        |-> ##[1:2] frame_sync_n)
        else $error("frame not closed after sixteen bits");
    a_frame_gap: assert property ($rose(frame_sync_n) |=> frame_sync_n)
        else $error("frames not separated");
    c_frame_done: cover property ($rose(frame_sync_n));
    c_byte_gap: cover property ((!frame_sync_n && st.cnt == 5'h08 && sclk) [*8]);
    c_frame_start: cover property ($fell(frame_sync_n));
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top
    import fsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, req_valid, req_ready, req_byte_mode, req_lsb_first;
    logic [15:0] req_word, word, word2;
    logic [3:0] ctrl, addr;
    logic [7:0] data;
    logic wv, wv2, sf2, lf2;
    int bad_count, checked, cycles, vc, vc2, sc2, lc2;
    fsr_link_if link_a ();
    fsr_link_if link_b ();
    fsr_host_end fsr_host_end_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_word(req_word), .req_byte_mode(req_byte_mode),
        .req_lsb_first(req_lsb_first), .link(link_a));
    fsr_device_end fsr_device_end_i (.link(link_a), .clk(clk), .rst_n(rst_n), .word_valid(wv),
        .word(word), .word_ctrl(ctrl), .word_addr(addr), .word_data(data),
        .short_frame(), .long_frame());
    // Second device faces a bench driver that breaks the framing on purpose.
    fsr_device_end fsr_device_end_b_i (.link(link_b), .clk(clk), .rst_n(rst_n),
        .word_valid(wv2), .word(word2), .word_ctrl(), .word_addr(), .word_data(),
        .short_frame(sf2), .long_frame(lf2));
    fsr_link_checker fsr_link_checker_i (.clk(clk), .rst_n(rst_n), .sclk(link_a.sclk),
        .frame_sync_n(link_a.frame_sync_n), .serial_data_in(link_a.serial_data_in));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        vc += int'(wv === 1'b1);
        vc2 += int'(wv2 === 1'b1);
        sc2 += int'(sf2 === 1'b1);
        lc2 += int'(lf2 === 1'b1);
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic send(input logic [15:0] w, input logic bm, input logic lf);
        int n;
        int v0;
        logic [15:0] exp;
        if (lf)
            exp = {<<{w}};
        else
            exp = w;
        v0 = vc;
        @(negedge clk);
        req_valid = 1'b1;
        req_word = w;
        req_byte_mode = bm;
        req_lsb_first = lf;
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge clk);
        end
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (vc == v0 && n < 300)
        begin
            n++;
            @(negedge clk);
        end
        check("word count", 16'(vc - v0), 16'h0001);
        check("word", word, exp);
        check("ctrl", 16'(ctrl), 16'(exp[15:12]));
        check("addr", 16'(addr), 16'(exp[11:8]));
        check("data", 16'(data), 16'(exp[7:0]));
    endtask
    // Bench link clock runs at 32 ns and stands parked between frames.
    task automatic drv(input logic [16:0] bits, input int n, input logic park);
        link_b.frame_sync_n = 1'b0;
        #16;
        for (int i = n - 1; i >= 0; i--)
        begin
            link_b.sclk = 1'b1;
            link_b.serial_data_in = bits[i];
            #16 link_b.sclk = 1'b0;
            #16;
        end
        link_b.sclk = 1'b1;
        #16 link_b.frame_sync_n = 1'b1;
        link_b.serial_data_in = ~bits[0];
        #16 link_b.sclk = park;
        repeat (8) @(negedge clk);
    endtask
    task automatic t_words();
        logic [15:0] tbl [5] = '{16'h8001, 16'h7ffe, 16'ha5c3, 16'h1e2d, 16'hffff};
        // Every pairing of byte mode and bit order, each word checked before the next frame.
        for (int i = 0; i < 5; i++)
            send(tbl[i], i[1], i[0]);
        $display("test words done");
    endtask
    task automatic t_frames();
        drv(17'h000b4, 8, 1'b0);
        drv(17'h03c96, 16, 1'b0);
        check("short count", 16'(sc2), 16'h0001);
        check("short word", word2, 16'h3c96);
        drv({16'h5a0f, 1'b1}, 17, 1'b1);
        check("long count", 16'(lc2), 16'h0001);
        check("valid count", 16'(vc2), 16'h0002);
        check("long word", word2, 16'h5a0f);
        $display("test frames done");
    endtask
    initial
    begin
        {bad_count, checked, cycles, vc, vc2, sc2, lc2} = '0;
        rst_n = 1'b0;
        {req_valid, req_byte_mode, req_lsb_first} = 3'h0;
        req_word = 16'h0000;
        link_b.sclk = 1'b1;
        link_b.frame_sync_n = 1'b1;
        link_b.serial_data_in = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_words();
        t_frames();
        complete_run();
    end
endmodule
`default_nettype wire
